// ===== dv/sdl_host_model.sv
// serial link controller model driving frame select, serial clock and data
`timescale 1ns/1ps

module sdl_host_model (
    // serial link pins
    output logic sync_n,
    output logic sclk,
    output logic din
);
    initial begin
        sync_n <= 1'b1;
        sclk   <= 1'b0;
        din    <= 1'b0;
    end

    // sends the first nbits of a frame msb first; park leaves frame select low after it
    task automatic send(input logic [23:0] frame, input int nbits, input bit park);
        // a parked line goes high shortly before the next start edge
        sync_n <= 1'b1;
        #400;
        sync_n <= 1'b0;
        #400;
        for (int i = 23; i > 23 - nbits; i--) begin
            sclk <= 1'b1;
            din  <= frame[i];
            #400;
            sclk <= 1'b0;
            #400;
            // byte-wide hosts pause between bytes with frame select still low
            if (i % 8 == 0 && i > 0)
                #800;
        end
        // data line no longer held once the frame ends
        din <= ~din;
        if (!park)
            sync_n <= 1'b1;
        else
            sync_n <= 1'b0;
        #800;
    endtask : send
endmodule : sdl_host_model

// ===== dv/testbench.sv
// self-checking bench of the serial loader with register bus and link model
`timescale 1ns/1ps
`include "sdl_consts.svh"

module testbench;
    import sdl_pkg::*;
    logic         aclk = 1'b0, aresetn = 1'b0, por_midscale = 1'b1;
    logic [7:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]  s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]   s_axi_wstrb = 4'hF;
    logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp, r;
    logic         sync_n, sclk, din;
    logic [15:0]  dac_core_code, core;
    sdl_code_type dac_applied_code;
    logic [17:0]  code;
    logic [31:0]  d;
    int           mismatches = 0, n_tests = 0, n_frames = 0, n_hi, n_lo;

    sdl_loader sdl_loader_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync_n, .sclk, .din,
        .por_midscale, .dac_core_code, .dac_applied_code);
    sdl_host_model sdl_host_model_i (.sync_n, .sclk, .din);

    initial begin
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_rd(a);
        chk(d, e);
        chk(r, `SDL_RESP_OKAY);
    endtask : rd_chk

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    initial begin
        // tests take about 40k clock cycles
        #6ms;
        mismatches++;
        final_report();
    end

    initial begin
        void'($urandom(32'h6afbcd9f));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(32'(dac_applied_code), 32'(`SDL_CODE_MID));
        rd_chk(`SDL_OFF_CODE, 32'(`SDL_CODE_MID));
        axi_wr(8'h40, 32'hFFFF_FFFF);
        chk(r, `SDL_RESP_SLVERR);
        axi_rd(8'h40);
        chk(r, `SDL_RESP_SLVERR);
        // every selector value with a random core, ignored bits set
        for (int s = 0; s < 4; s++) begin
            core = 16'($urandom_range(32'hFFFE));
            code = {core, 2'(s)};
            sdl_host_model_i.send({4'hC, code, 2'b11}, 24, 1'b0);
            n_frames++;
            repeat (4) @(posedge aclk);
            rd_chk(`SDL_OFF_CODE, 32'(code));
            n_hi = 0;
            while (dac_applied_code !== code && n_hi < 2100) begin
                @(posedge aclk);
                n_hi++;
            end
            chk(32'(dac_applied_code), 32'(code));
            @(posedge aclk);
            n_hi = 0;
            n_lo = 0;
            repeat (1000) begin
                @(posedge aclk);
                n_hi += int'(dac_core_code === core + 16'h1);
                n_lo += int'(dac_core_code === core);
            end
            chk(n_hi, s * 250);
            chk(n_lo, 1000 - s * 250);
        end
        // frame cut after 23 bits is discarded
        sdl_host_model_i.send(24'hFFFFFF, 23, 1'b0);
        rd_chk(`SDL_OFF_CODE, 32'(code));
        rd_chk(`SDL_OFF_ABORTS, 32'h1);
        rd_chk(`SDL_OFF_FRAMES, n_frames);
        axi_wr(`SDL_OFF_CTRL, 32'h0);
        sdl_host_model_i.send(24'h0FFFFC, 24, 1'b0);
        rd_chk(`SDL_OFF_CODE, 32'(code));
        axi_wr(`SDL_OFF_CTRL, 32'h1);
        // back to back frames overrun the code fifo
        repeat (24) begin
            code = 18'($urandom);
            sdl_host_model_i.send({4'h0, code, 2'b00}, 24, 1'b1);
            n_frames++;
        end
        axi_rd(`SDL_OFF_STATUS);
        chk(d[2], 1'b1);
        repeat (25000) @(posedge aclk);
        axi_rd(`SDL_OFF_STATUS);
        chk(d[4], 1'b0);
        rd_chk(`SDL_OFF_CODE, 32'(code));
        axi_rd(`SDL_OFF_FRAMES);
        chk(d[15:0], n_frames[15:0]);
        chk(32'(d[31:16] != 16'h0), 32'h1);
        // second reset with the zero-scale strap
        aresetn      <= 1'b0;
        por_midscale <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(32'(dac_applied_code), 32'(`SDL_CODE_ZERO));
        chk(32'(dac_core_code), 32'h0);
        rd_chk(`SDL_OFF_CODE, 32'(`SDL_CODE_ZERO));
        final_report();
    end
endmodule : testbench

// ===== verilog/sdl_consts.svh
// constants of the serial converter loader and interpolator
`ifndef SDL_CONSTS_SVH
`define SDL_CONSTS_SVH
`define SDL_CLK_HZ          10000000
`define SDL_INTERP_HZ       10000
`define SDL_PERIOD_CYC      (`SDL_CLK_HZ / `SDL_INTERP_HZ)
`define SDL_QUARTER_CYC     (`SDL_PERIOD_CYC / 4)
`define SDL_FRAME_BITS      24
`define SDL_CODE_MSB        19
`define SDL_CODE_LSB        2
`define SDL_CODE_ZERO       18'h00000
`define SDL_CODE_MID        18'h20000
`define SDL_CORE_MAX        16'hFFFF
`define SDL_FIFO_DEPTH      16
`define SDL_FIFO_WIDTH      18
`define SDL_OFF_CTRL        8'h00
`define SDL_OFF_STATUS      8'h04
`define SDL_OFF_CODE        8'h08
`define SDL_OFF_APPLIED     8'h0C
`define SDL_OFF_FRAMES      8'h10
`define SDL_OFF_ABORTS      8'h14
`define SDL_CTRL_RESET      1'b1
`define SDL_RESP_OKAY       2'b00
`define SDL_RESP_SLVERR     2'b10
`endif

// ===== verilog/sdl_loader.sv
// serial frame loader, code fifo, interpolator and axi4-lite register slave
`timescale 1ns/1ps
`include "sdl_consts.svh"

module sdl_fifo #(
    parameter int WIDTH = `SDL_FIFO_WIDTH,
    parameter int DEPTH = `SDL_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      wr_ptr_next;
    logic [AW:0]      rd_ptr_reg;
    logic [AW:0]      rd_ptr_next;

    assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];

    always_comb begin
        wr_ptr_next = wr_ptr_reg + (AW+1)'(in_valid && in_ready);
        rd_ptr_next = rd_ptr_reg + (AW+1)'(out_valid && out_ready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule : sdl_fifo

module sdl_loader (
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // axi4-lite write
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // serial link pins
    input  wire logic                sync_n,
    input  wire logic                sclk,
    input  wire logic                din,
    // power-on level strap, high selects midscale
    input  wire logic                por_midscale,
    // core converter drive
    output logic [15:0]              dac_core_code,
    output sdl_pkg::sdl_code_type    dac_applied_code
);
    import sdl_pkg::*;

    localparam logic [9:0] PERIOD_LAST = 10'(`SDL_PERIOD_CYC - 1);

    function automatic logic fell(input logic prev, input logic cur);
        return prev && !cur;
    endfunction : fell

    function automatic logic [9:0] hi_limit(input logic [1:0] sel);
        return 10'(sel) * 10'(`SDL_QUARTER_CYC);
    endfunction : hi_limit

    // pin synchronisers, third stage only for edge finding
    logic [2:0] sync_sh_reg;
    logic [2:0] sclk_sh_reg;
    logic [1:0] din_sh_reg;
    logic [1:0] strap_sh_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_sh_reg  <= 3'h7;
            sclk_sh_reg  <= 3'h0;
            din_sh_reg   <= 2'h0;
            strap_sh_reg <= 2'h0;
        end else begin
            sync_sh_reg  <= {sync_sh_reg[1:0], sync_n};
            sclk_sh_reg  <= {sclk_sh_reg[1:0], sclk};
            din_sh_reg   <= {din_sh_reg[0], din};
            strap_sh_reg <= {strap_sh_reg[0], por_midscale};
        end
    end
    logic sync_fall;
    logic sync_rise;
    logic sclk_fall;
    logic din_s;
    assign sync_fall = fell(sync_sh_reg[2], sync_sh_reg[1]);
    assign sync_rise = fell(!sync_sh_reg[2], !sync_sh_reg[1]);
    assign sclk_fall = fell(sclk_sh_reg[2], sclk_sh_reg[1]);
    assign din_s     = din_sh_reg[1];

    // link group: shifter, code register, counters
    sdl_link_state_type lk_state_reg, lk_state_next;
    logic [23:0]  shift_reg,  shift_next;
    logic [4:0]   bits_reg,   bits_next;
    sdl_code_type code_reg,   code_next;
    sdl_code_type pdata_reg,  pdata_next;
    logic         pend_reg,   pend_next;
    logic         loaded_reg, loaded_next;
    logic [1:0]   init_reg,   init_next;
    logic [15:0]  frames_reg, frames_next;
    logic [15:0]  ovr_reg,    ovr_next;
    logic [15:0]  aborts_reg, aborts_next;
    logic         ctrl_en_reg;
    logic         fifo_in_ready;
    logic         frame_done;
    sdl_code_type por_code;
    assign por_code   = strap_sh_reg[1] ? `SDL_CODE_MID : `SDL_CODE_ZERO;
    assign frame_done = lk_state_reg == LK_SHIFT && !sync_rise && sclk_fall
                        && bits_reg == 5'(`SDL_FRAME_BITS - 1);

    always_comb begin
        lk_state_next = lk_state_reg;
        shift_next    = shift_reg;
        bits_next     = bits_reg;
        code_next     = code_reg;
        pdata_next    = pdata_reg;
        pend_next     = pend_reg && !fifo_in_ready;
        loaded_next   = loaded_reg;
        init_next     = (init_reg == 2'h3) ? init_reg : init_reg + 2'h1;
        frames_next   = frames_reg;
        ovr_next      = ovr_reg;
        aborts_next   = aborts_reg;
        if (init_reg == 2'h2) begin
            code_next = por_code;
        end
        unique case (lk_state_reg)
            LK_IDLE: begin
                if (sync_fall && ctrl_en_reg && init_reg == 2'h3) begin
                    lk_state_next = LK_SHIFT;
                    shift_next    = '0;
                    bits_next     = '0;
                end
            end
            LK_SHIFT: begin
                if (sync_rise) begin
                    lk_state_next = LK_IDLE;
                    shift_next    = '0;
                    bits_next     = '0;
                    aborts_next   = aborts_reg + 16'h1;
                end else if (sclk_fall) begin
                    shift_next = {shift_reg[22:0], din_s};
                    bits_next  = bits_reg + 5'h1;
                    if (frame_done) begin
                        // 24th edge: reserved and trailing bits dropped
                        code_next     = sdl_code_type'(shift_reg[18:1]);
                        loaded_next   = 1'b1;
                        frames_next   = frames_reg + 16'h1;
                        lk_state_next = LK_HOLD;
                        if (!pend_next) begin
                            pend_next  = 1'b1;
                            pdata_next = sdl_code_type'(shift_reg[18:1]);
                        end else begin
                            ovr_next = ovr_reg + 16'h1;
                        end
                    end
                end
            end
            LK_HOLD: begin
                if (sync_rise) begin
                    lk_state_next = LK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lk_state_reg <= LK_IDLE;
            shift_reg    <= '0;
            bits_reg     <= '0;
            code_reg     <= `SDL_CODE_ZERO;
            pdata_reg    <= `SDL_CODE_ZERO;
            pend_reg     <= 1'b0;
            loaded_reg   <= 1'b0;
            init_reg     <= 2'h0;
            frames_reg   <= 16'h0;
            ovr_reg      <= 16'h0;
            aborts_reg   <= 16'h0;
        end else begin
            lk_state_reg <= lk_state_next;
            shift_reg    <= shift_next;
            bits_reg     <= bits_next;
            code_reg     <= code_next;
            pdata_reg    <= pdata_next;
            pend_reg     <= pend_next;
            loaded_reg   <= loaded_next;
            init_reg     <= init_next;
            frames_reg   <= frames_next;
            ovr_reg      <= ovr_next;
            aborts_reg   <= aborts_next;
        end
    end

    // code fifo between loader and interpolator
    logic         fifo_out_valid;
    logic         fifo_out_ready;
    sdl_code_type fifo_out_data;
    sdl_fifo #(
        .WIDTH ($bits(sdl_code_type)),
        .DEPTH (`SDL_FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (pend_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (pdata_reg),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // interpolator group
    logic [9:0]   cnt_reg, cnt_next;
    sdl_code_type app_reg, app_next;
    logic [15:0]  core_reg, core_next;
    assign fifo_out_ready = cnt_reg == PERIOD_LAST;

    always_comb begin
        cnt_next  = (cnt_reg == PERIOD_LAST) ? 10'h0 : cnt_reg + 10'h1;
        app_next  = app_reg;
        core_next = app_reg.core;
        if (init_reg == 2'h2) begin
            app_next = por_code;
        end else if (fifo_out_ready && fifo_out_valid) begin
            app_next = fifo_out_data;
        end
        // top code has no C+1, it stays at full scale
        if (cnt_reg < hi_limit(app_reg.sel) && app_reg.core != `SDL_CORE_MAX) begin
            core_next = app_reg.core + 16'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg  <= 10'h0;
            app_reg  <= `SDL_CODE_ZERO;
            core_reg <= 16'h0;
        end else begin
            cnt_reg  <= cnt_next;
            app_reg  <= app_next;
            core_reg <= core_next;
        end
    end
    assign dac_core_code    = core_reg;
    assign dac_applied_code = app_reg;

    // axi4-lite slave group
    logic        awready_reg, awready_next, wready_reg, wready_next;
    logic        bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic        rvalid_reg, rvalid_next;
    logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0]  awaddr_reg, awaddr_next, rd_addr;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0]  wstrb_reg, wstrb_next;
    logic        ctrl_en_next;

    always_comb begin
        awready_next = awready_reg;
        wready_next  = wready_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        arready_next = arready_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        ctrl_en_next = ctrl_en_reg;
        rd_addr      = {s_axi_araddr[7:2], 2'b00};
        if (s_axi_awvalid && awready_reg) begin
            awaddr_next  = {s_axi_awaddr[7:2], 2'b00};
            awready_next = 1'b0;
        end
        if (s_axi_wvalid && wready_reg) begin
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
            wready_next = 1'b0;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next  = 1'b0;
            awready_next = 1'b1;
            wready_next  = 1'b1;
        end
        if (!awready_reg && !wready_reg && !bvalid_reg) begin
            bvalid_next = 1'b1;
            bresp_next  = `SDL_RESP_OKAY;
            if (awaddr_reg == `SDL_OFF_CTRL) begin
                if (wstrb_reg[0]) begin
                    ctrl_en_next = wdata_reg[0];
                end
            end else if (awaddr_reg > `SDL_OFF_ABORTS) begin
                bresp_next = `SDL_RESP_SLVERR;
            end
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next  = 1'b0;
            arready_next = 1'b1;
        end
        if (s_axi_arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next  = 1'b1;
            rresp_next   = `SDL_RESP_OKAY;
            unique case (rd_addr)
                `SDL_OFF_CTRL:    rdata_next = {31'h0, ctrl_en_reg};
                `SDL_OFF_STATUS:  rdata_next = {27'h0, fifo_out_valid, loaded_reg,
                                                !fifo_in_ready, pend_reg,
                                                lk_state_reg == LK_SHIFT};
                `SDL_OFF_CODE:    rdata_next = {14'h0, code_reg};
                `SDL_OFF_APPLIED: rdata_next = {14'h0, app_reg};
                `SDL_OFF_FRAMES:  rdata_next = {ovr_reg, frames_reg};
                `SDL_OFF_ABORTS:  rdata_next = {16'h0, aborts_reg};
                default: begin
                    rdata_next = 32'h0;
                    rresp_next = `SDL_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= 2'h0;
            rdata_reg   <= 32'h0;
            awaddr_reg  <= 8'h0;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            ctrl_en_reg <= `SDL_CTRL_RESET;
        end else begin
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            ctrl_en_reg <= ctrl_en_next;
        end
    end
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_CORE_RANGE: assert property (
        dac_core_code == $past(app_reg.core) || dac_core_code == $past(app_reg.core) + 16'h1)
        else $error("core code left the C to C+1 range");
    AST_SPLIT: assert property (frame_done |=> code_reg == $past(shift_reg[18:1]))
        else $error("code register not taken from the code bits of the frame");
    AST_LAST_QUARTER: assert property (
        cnt_reg >= 10'(3 * `SDL_QUARTER_CYC) |=> dac_core_code == $past(app_reg.core))
        else $error("high code driven in the last quarter");
    AST_HIGH_PHASE: assert property (
        cnt_reg < hi_limit(app_reg.sel) && app_reg.core != `SDL_CORE_MAX
        |=> dac_core_code == $past(app_reg.core) + 16'h1)
        else $error("high code missing in its duty window");
    AST_PERIOD: assert property (cnt_reg == PERIOD_LAST |=> cnt_reg == 10'h0)
        else $error("switching period length wrong");
    AST_START: assert property (
        lk_state_reg == LK_IDLE && !sync_fall |=> lk_state_reg == LK_IDLE)
        else $error("frame started without a falling frame select");
    AST_SHIFT: assert property (
        lk_state_reg == LK_SHIFT && sclk_fall && !sync_rise |=> shift_reg[0] == $past(din_s))
        else $error("serial data not shifted in");
    AST_DONE_24: assert property (
        frame_done |=> lk_state_reg == LK_HOLD && frames_reg == $past(frames_reg) + 16'h1)
        else $error("frame not completed on the 24th edge");
    AST_ABORT: assert property (
        lk_state_reg == LK_SHIFT && sync_rise
        |=> shift_reg == 24'h0 && $stable(code_reg) && lk_state_reg == LK_IDLE)
        else $error("aborted frame changed state");
    AST_POR: assert property (
        init_reg == 2'h2 |=> app_reg == $past(por_code) ##1 init_reg == 2'h3)
        else $error("power-on code not loaded");
    AST_BOUNDARY: assert property (
        init_reg == 2'h3 && cnt_reg != PERIOD_LAST |=> $stable(app_reg))
        else $error("applied code changed inside a period");

    COV_FRAME: cover property (frame_done);
    COV_ABORT: cover property (lk_state_reg == LK_SHIFT && sync_rise);
    COV_FULL: cover property (!fifo_in_ready);
    COV_DUTY75: cover property (app_reg.sel == 2'h3 && cnt_reg == 10'h1);
endmodule : sdl_loader

// ===== verilog/sdl_pkg.sv
// types of the serial converter loader and interpolator
package sdl_pkg;
    typedef struct packed {
        logic [15:0] core;
        logic [1:0]  sel;
    } sdl_code_type;

    typedef enum logic [1:0] {LK_IDLE, LK_SHIFT, LK_HOLD} sdl_link_state_type;
endpackage : sdl_pkg
